/* can_remote_frame_timing.sv */
// Purpose: CAN bit timing, frame receive/transmit and remote-frame answer engine
// Assumes: No bit stuffing, CRC or arbitration-loss handling on the simplified link
// Notes:   APB slave answers with zero wait states
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module can_remote_frame_timing import can_rf_pkg::*; #(
  parameter int NBUF = 15
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic enable;
    bit_timing_type tim;
    logic [31:0] global_accept_mask;
    logic [31:0] basic_accept_mask;
    logic [NBUF-1:0][31:0] buf_id;
    logic [NBUF-1:0][3:0] buf_st;
    logic [2:0] rx_sync;
    logic [6:0] pre_cnt;
    phase_type phase;
    logic [4:0] tq_cnt;
    logic [4:0] seg_len;
    rx_state_type rx_st;
    logic [5:0] bit_cnt;
    logic [31:0] hidden;
    logic tx_act;
    logic [32:0] tx_shift;
    logic tx_sel_vld;
    logic [3:0] tx_sel;
    logic tx_pin;
    eng_state_type eng;
    logic [4:0] eng_cnt;
    logic [15:0] upd_pend;
    logic [31:0] eng_obj;
    logic [3:0] rx_hit;
    logic rx_hit_vld;
    logic [31:0] rdata;
    logic err;
  } state_type;

  state_type st_ff;
  state_type nxt_st;

  logic [6:0] tq_len;
  logic [4:0] t1;
  logic [4:0] t2;
  logic [4:0] jump;
  logic tq_tick;
  logic seg_last;
  logic rx_bit;
  logic fall;
  logic acc;
  logic in_id;
  logic in_st;
  logic [3:0] bidx;
  logic bok;
  logic cpu_buf;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mask bit 1 means the object bit must equal the buffer bit
  function automatic logic accept(input logic [31:0] obj, input logic [31:0] id,
                                  input logic [31:0] mask);
    accept = ((obj ^ id) & mask) == 32'h0000_0000;
  endfunction

  // Lowest set bit as {found, index}
  function automatic logic [4:0] first_set(input logic [15:0] v);
    first_set = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        first_set = {1'b1, 4'(i)};
      end
    end
  endfunction

  // Effective timing from the fields [RULE9] [RULE8]
  assign tq_len = {1'b0, st_ff.tim.quantum_prescaler} + PRE_ADD;
  assign t1 = {1'b0, st_ff.tim.first_time_segment} + SEG_ADD;
  assign t2 = {2'b00, st_ff.tim.second_time_segment} + SEG_ADD;
  assign jump = {3'b000, st_ff.tim.resync_jump_width} + SEG_ADD;
  assign tq_tick = st_ff.pre_cnt == tq_len - 7'h01; // [RULE7]
  assign seg_last = tq_tick && (st_ff.tq_cnt == st_ff.seg_len - 5'h01);
  assign rx_bit = st_ff.rx_sync[1];
  assign fall = st_ff.rx_sync[2] & ~st_ff.rx_sync[1];

  // APB decode
  assign acc = psel & penable;
  assign in_id = paddr[11:6] == REGION_BUF_ID;
  assign in_st = paddr[11:6] == REGION_BUF_ST;
  assign bidx = paddr[5:2];
  assign bok = 32'(bidx) < NBUF;
  assign cpu_buf = acc & (in_id | in_st) & bok; // [RULE4]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic bstart;
    logic fv;
    logic remote;
    logic [15:0] rx_hits;
    logic [15:0] upd_hits;
    logic [15:0] cand;
    logic [4:0] f;
    logic [31:0] m;
    logic [31:0] txo;
    logic [31:0] rd;
    bstart = 1'b0;
    fv = 1'b0;
    remote = 1'b0;
    rx_hits = 16'h0000;
    upd_hits = 16'h0000;
    cand = 16'h0000;
    f = 5'h00;
    m = 32'h0000_0000;
    txo = 32'h0000_0000;
    rd = 32'h0000_0000;
    nxt_st = st_ff;

    // Two-stage pin synchroniser plus history stage
    nxt_st.rx_sync = {st_ff.rx_sync[1:0], bus_receive_pin}; // [RULE16]

    // Quantum prescaler and segment sequence [RULE7]
    nxt_st.pre_cnt = tq_tick ? 7'h00 : st_ff.pre_cnt + 7'h01;
    if (tq_tick) begin
      nxt_st.tq_cnt = st_ff.tq_cnt + 5'h01;
      if (seg_last) begin
        nxt_st.tq_cnt = 5'h00;
        case (st_ff.phase)
          P_SYNC: begin
            nxt_st.phase = P_SEG1;
            nxt_st.seg_len = t1;
          end
          P_SEG1: begin
            nxt_st.phase = P_SEG2;
            nxt_st.seg_len = t2;
          end
          default: begin
            nxt_st.phase = P_SYNC;
            nxt_st.seg_len = SEG_ADD;
            bstart = 1'b1;
          end
        endcase
      end
    end

    // Hard sync in idle, resync bounded by the jump width [RULE17]
    if (fall && st_ff.enable && !st_ff.tx_act) begin
      if (st_ff.rx_st == R_IDLE ||
          (st_ff.phase == P_SEG2 && (st_ff.seg_len - st_ff.tq_cnt) <= jump)) begin
        nxt_st.phase = P_SEG1;
        nxt_st.tq_cnt = 5'h00;
        nxt_st.pre_cnt = 7'h00;
        nxt_st.seg_len = t1;
        bstart = 1'b1;
      end else if (st_ff.phase == P_SEG1) begin
        nxt_st.seg_len = t1 + ((st_ff.tq_cnt + 5'h01 < jump) ? st_ff.tq_cnt + 5'h01 : jump);
      end else if (st_ff.phase == P_SEG2) begin
        nxt_st.seg_len = st_ff.seg_len - jump;
      end
    end

    // Receiver, stepped at the sample point [RULE17]
    if (!st_ff.enable) begin
      nxt_st.rx_st = R_IFS;
      nxt_st.bit_cnt = 6'h00;
    end else if (seg_last && st_ff.phase == P_SEG1) begin
      case (st_ff.rx_st)
        R_IFS: begin
          if (!rx_bit) begin
            nxt_st.bit_cnt = 6'h00;
          end else if (st_ff.bit_cnt == IDLE_BITS - 6'h01) begin
            nxt_st.rx_st = R_IDLE; // [RULE5]
          end else begin
            nxt_st.bit_cnt = st_ff.bit_cnt + 6'h01;
          end
        end
        R_IDLE: begin
          if (!rx_bit) begin
            nxt_st.rx_st = R_DATA;
            nxt_st.bit_cnt = 6'h00;
          end
        end
        R_DATA: begin
          nxt_st.hidden = {st_ff.hidden[30:0], rx_bit};
          nxt_st.bit_cnt = st_ff.bit_cnt + 6'h01;
          if (st_ff.bit_cnt == OBJ_LAST_BIT) begin
            nxt_st.rx_st = R_EOF;
            nxt_st.bit_cnt = 6'h00;
          end
        end
        default: begin
          if (!rx_bit) begin
            nxt_st.rx_st = R_IFS;
            nxt_st.bit_cnt = 6'h00;
            nxt_st.tx_act = 1'b0;
          end else if (st_ff.bit_cnt == VALID_EOF_BIT - 6'h01) begin
            fv = 1'b1; // [RULE5]
            nxt_st.rx_st = R_IFS;
            nxt_st.bit_cnt = IDLE_BITS - START_GAP_BITS; // [RULE5]
          end else begin
            nxt_st.bit_cnt = st_ff.bit_cnt + 6'h01;
          end
        end
      endcase
    end

    // Transmitter: completion on own valid frame, then start/shift
    if (fv && st_ff.tx_act) begin
      nxt_st.tx_act = 1'b0;
      nxt_st.tx_sel_vld = 1'b0;
      nxt_st.buf_st[st_ff.tx_sel] = (st_ff.buf_st[st_ff.tx_sel] == TX_REMOTE) ?
                                    RX_REPLY : TX_IDLE; // [RULE15]
    end
    if (!st_ff.enable) begin
      nxt_st.tx_act = 1'b0;
      nxt_st.tx_pin = 1'b1;
    end else if (bstart) begin
      if (st_ff.tx_act) begin
        nxt_st.tx_pin = st_ff.tx_shift[32];
        nxt_st.tx_shift = {st_ff.tx_shift[31:0], 1'b1};
      end else if (st_ff.rx_st == R_IDLE && st_ff.tx_sel_vld) begin
        txo = st_ff.buf_id[st_ff.tx_sel];
        if (st_ff.buf_st[st_ff.tx_sel] == TX_ONCE_REMOTE_STATUS) begin
          txo[OBJ_SRTR] = txo[OBJ_IDE]; // [RULE13]
          txo[OBJ_XREM] = 1'b0; // [RULE13]
        end else if (st_ff.buf_st[st_ff.tx_sel] == TX_REMOTE) begin
          txo[txo[OBJ_IDE] ? OBJ_XREM : OBJ_SRTR] = 1'b1;
        end
        nxt_st.tx_act = 1'b1;
        nxt_st.tx_pin = 1'b0;
        nxt_st.tx_shift = {txo, 1'b1};
      end else begin
        nxt_st.tx_pin = 1'b1;
      end
    end

    // Acceptance for the frame just validated [RULE11] [RULE12]
    remote = st_ff.hidden[OBJ_IDE] ? st_ff.hidden[OBJ_XREM] : st_ff.hidden[OBJ_SRTR];
    for (int i = 0; i < NBUF; i++) begin
      m = (i == NBUF - 1) ? st_ff.basic_accept_mask : st_ff.global_accept_mask;
      if (st_ff.buf_st[i] == RX_REPLY) begin
        m[OBJ_SRTR] = 1'b0; // [RULE15]
        m[OBJ_XREM] = 1'b0; // [RULE15]
      end
      if (accept(st_ff.hidden, st_ff.buf_id[i], m)) begin
        if (st_ff.buf_st[i] inside {RX_EMPTY, RX_FULL, RX_REPLY}) begin
          rx_hits[i] = 1'b1;
        end
        if (remote && st_ff.buf_st[i] == TX_REMOTE_WAIT_STATUS) begin
          upd_hits[i] = 1'b1; // [RULE13]
        end
      end
      if (st_ff.buf_st[i] inside {TX_DATA, TX_REMOTE, TX_ONCE_REMOTE_STATUS}) begin
        cand[i] = 1'b1;
      end
    end

    // Processing engine, stalled by CPU buffer access [RULE4] [RULE6]
    if (!cpu_buf && st_ff.eng != E_IDLE) begin
      nxt_st.eng_cnt = st_ff.eng_cnt + 5'h01;
    end
    case (st_ff.eng)
      E_IDLE: begin
        nxt_st.eng_cnt = 5'h00;
        f = first_set(rx_hits);
        if (fv && !st_ff.tx_act) begin
          nxt_st.eng_obj = st_ff.hidden;
          nxt_st.rx_hit = f[3:0];
          nxt_st.upd_pend = upd_hits;
          nxt_st.eng = f[4] ? E_COPY : ((upd_hits != 16'h0000) ? E_UPDATE : E_SCHED);
        end else if (!st_ff.tx_sel_vld && !st_ff.tx_act && cand != 16'h0000) begin
          nxt_st.eng = E_SCHED;
        end
      end
      E_COPY: begin
        if (!cpu_buf && st_ff.eng_cnt == COPY_CYCLES - 5'h01) begin
          nxt_st.buf_id[st_ff.rx_hit] = st_ff.eng_obj; // [RULE1]
          nxt_st.buf_st[st_ff.rx_hit] = RX_FULL;
          nxt_st.eng_cnt = 5'h00;
          nxt_st.eng = (st_ff.upd_pend != 16'h0000) ? E_UPDATE : E_SCHED;
        end
      end
      E_UPDATE: begin
        f = first_set(st_ff.upd_pend);
        if (!cpu_buf && st_ff.eng_cnt == UPDATE_CYCLES - 5'h01) begin
          nxt_st.buf_st[f[3:0]] = TX_ONCE_REMOTE_STATUS; // [RULE2]
          nxt_st.upd_pend[f[3:0]] = 1'b0;
          nxt_st.eng_cnt = 5'h00;
          if ((st_ff.upd_pend & (st_ff.upd_pend - 16'h0001)) == 16'h0000) begin
            nxt_st.eng = E_SCHED;
          end
        end
      end
      E_SCHED: begin
        f = first_set(cand);
        if (!cpu_buf && st_ff.eng_cnt == SCHED_CYCLES - 5'h01) begin
          if (!st_ff.tx_act) begin
            nxt_st.tx_sel = f[3:0]; // [RULE3]
            nxt_st.tx_sel_vld = f[4];
          end
          nxt_st.eng_cnt = 5'h00;
          nxt_st.eng = E_IDLE;
        end
      end
      default: begin
        nxt_st.eng = E_IDLE;
      end
    endcase

    // APB read data and error captured in the setup phase
    if (psel && !penable) begin
      nxt_st.err = 1'b0;
      if (in_id && bok) begin
        rd = st_ff.buf_id[bidx];
      end else if (in_st && bok) begin
        rd = {28'h0000000, st_ff.buf_st[bidx]};
      end else begin
        case (paddr)
          ADDR_CTRL: rd = {31'h00000000, st_ff.enable};
          ADDR_TIMING: begin
            rd[TIM_PRE_LSB +: 6] = st_ff.tim.quantum_prescaler;
            rd[TIM_SEG1_LSB +: 4] = st_ff.tim.first_time_segment;
            rd[TIM_SEG2_LSB +: 3] = st_ff.tim.second_time_segment;
            rd[TIM_JMP_LSB +: 2] = st_ff.tim.resync_jump_width;
          end
          ADDR_GMASK: rd = st_ff.global_accept_mask;
          ADDR_BMASK: rd = st_ff.basic_accept_mask;
          ADDR_STATUS: begin
            rd[STS_ENG_LSB +: 3] = st_ff.eng;
            rd[STS_RX_LSB +: 2] = st_ff.rx_st;
            rd[STS_TXACT_BIT] = st_ff.tx_act;
            rd[STS_TXSEL_BIT] = st_ff.tx_sel_vld;
          end
          default: nxt_st.err = 1'b1;
        endcase
      end
      nxt_st.rdata = rd;
    end

    // APB writes take effect in the access phase
    if (acc && pwrite && !st_ff.err) begin
      if (in_id && bok) begin
        nxt_st.buf_id[bidx] = pwdata;
      end else if (in_st && bok) begin
        nxt_st.buf_st[bidx] = pwdata[3:0];
      end else begin
        case (paddr)
          ADDR_CTRL: nxt_st.enable = pwdata[0];
          ADDR_TIMING: begin
            nxt_st.tim.quantum_prescaler = pwdata[TIM_PRE_LSB +: 6];
            nxt_st.tim.first_time_segment = pwdata[TIM_SEG1_LSB +: 4];
            nxt_st.tim.second_time_segment = pwdata[TIM_SEG2_LSB +: 3];
            nxt_st.tim.resync_jump_width = pwdata[TIM_JMP_LSB +: 2];
          end
          ADDR_GMASK: nxt_st.global_accept_mask = pwdata; // [RULE11]
          ADDR_BMASK: nxt_st.basic_accept_mask = pwdata; // [RULE11]
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Whole state registered, constants on reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.tim <= {TIMING_RST[TIM_JMP_LSB +: 2], TIMING_RST[TIM_SEG2_LSB +: 3],
                    TIMING_RST[TIM_SEG1_LSB +: 4], TIMING_RST[TIM_PRE_LSB +: 6]};
      st_ff.global_accept_mask <= MASK_RST;
      st_ff.basic_accept_mask <= MASK_RST;
      st_ff.rx_sync <= 3'h7;
      st_ff.seg_len <= SEG_ADD;
      st_ff.tx_pin <= 1'b1;
      st_ff.phase <= P_SYNC;
      st_ff.rx_st <= R_IFS;
      st_ff.eng <= E_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign prdata = st_ff.rdata;
  assign pslverr = st_ff.err;
  assign pready = 1'b1;
  assign bus_transmit_pin = st_ff.tx_pin; // [RULE16]

endmodule
`default_nettype wire

/* can_rf_pkg.sv */
// Purpose: Shared constants and types for the CAN remote-frame timing block
// Assumes: APB register map, 32-bit data, one aligned word per register
// Notes:   Message object layout is id/control bits packed into 32 bits
//
// Behaviour
// RULE1 - Copying the hidden buffer to a matching receive buffer takes 17 clocks, once.
// RULE2 - Each matching remote-wait transmit buffer becomes once-remote, 3 clocks each.
// RULE3 - Scheduling one buffer for transmission takes 2 clocks, once per frame.
// RULE4 - CPU access to buffer memory stalls internal processing with wait cycles.
// RULE5 - Frame valid at 6th end-of-frame bit; transmit after third intermission bit.
// RULE6 - All remote-frame work must fit in the four-bit gap between frames.
// RULE7 - Bit is sync quantum plus two segments; quantum lasts prescaler clocks.
// RULE8 - Smallest timing: prescaler 2, segment one 2, segment two 1, 8 clocks.
// RULE9 - Prescaler is field plus two; segments are their fields plus one.
// RULE10 - Software keeps at least 15.25 clocks per bit when all buffers answer.
// RULE11 - Two acceptance masks, global and basic, filter incoming identifiers.
// RULE12 - Each mask covers 32 object bits: identifiers plus remote, SRTR, IDE.
// RULE13 - Received remote frame triggers sending the matching data frame, remote bit 0.
// RULE14 - Software sets remote-request mask bits to don't-care for automatic answers.
// RULE15 - Buffer awaiting a reply after a remote frame ignores the remote bits.
// RULE16 - Bus data leaves on one transmit pin and arrives on one receive pin.
// RULE17 - Sample between segments; resynchronisation moves a bit by at most jump width.
package can_rf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_TIMING = 12'h004;
  localparam logic [11:0] ADDR_GMASK = 12'h008;
  localparam logic [11:0] ADDR_BMASK = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;
  localparam logic [5:0] REGION_BUF_ID = 6'h01;
  localparam logic [5:0] REGION_BUF_ST = 6'h02;
  localparam logic [31:0] TIMING_RST = 32'h0000_0100;
  localparam logic [31:0] MASK_RST = 32'hFFFF_FFFF;
  localparam int TIM_PRE_LSB = 0;
  localparam int TIM_SEG1_LSB = 8;
  localparam int TIM_SEG2_LSB = 12;
  localparam int TIM_JMP_LSB = 16;
  localparam int STS_ENG_LSB = 0;
  localparam int STS_RX_LSB = 4;
  localparam int STS_TXACT_BIT = 6;
  localparam int STS_TXSEL_BIT = 7;

  // ----------------------------------------------------------------
  // Timing figures
  // ----------------------------------------------------------------
  localparam logic [6:0] PRE_ADD = 7'h02;
  localparam logic [4:0] SEG_ADD = 5'h01;
  localparam logic [4:0] COPY_CYCLES = 5'h11;
  localparam logic [4:0] UPDATE_CYCLES = 5'h03;
  localparam logic [4:0] SCHED_CYCLES = 5'h02;
  localparam logic [5:0] OBJ_LAST_BIT = 6'h1F;
  localparam logic [5:0] VALID_EOF_BIT = 6'h06;
  localparam logic [5:0] IDLE_BITS = 6'h0B;
  localparam logic [5:0] START_GAP_BITS = 6'h04;

  // Object bit positions
  localparam int OBJ_XREM = 0;
  localparam int OBJ_IDE = 19;
  localparam int OBJ_SRTR = 20;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    BUF_OFF = 4'h0, RX_EMPTY = 4'h1, RX_FULL = 4'h2, RX_REPLY = 4'h3,
    TX_IDLE = 4'h8, TX_DATA = 4'h9, TX_REMOTE = 4'hA,
    TX_REMOTE_WAIT_STATUS = 4'hB, TX_ONCE_REMOTE_STATUS = 4'hC
  } buf_status_type;
  typedef enum logic [2:0] {
    E_IDLE = 3'b000, E_COPY = 3'b001, E_UPDATE = 3'b010, E_SCHED = 3'b011
  } eng_state_type;
  typedef enum logic [1:0] {
    R_IFS = 2'b00, R_IDLE = 2'b01, R_DATA = 2'b10, R_EOF = 2'b11
  } rx_state_type;
  typedef enum logic [1:0] {
    P_SYNC = 2'b00, P_SEG1 = 2'b01, P_SEG2 = 2'b10
  } phase_type;
  typedef struct packed {
    logic [1:0] resync_jump_width;
    logic [2:0] second_time_segment;
    logic [3:0] first_time_segment;
    logic [5:0] quantum_prescaler;
  } bit_timing_type;

endpackage

/* can_rf_props.sv */
// Purpose: Port checker for the CAN remote-frame timing block
// Assumes: One clock domain, zero-wait APB slave, shadowed mask and timing registers
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module can_rf_props import can_rf_pkg::*; #(
  parameter int NBUF = 15
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_receive_pin,
  input wire logic bus_transmit_pin
);
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  logic [31:0] gmask_ff;
  logic [31:0] tim_ff;
  logic en_ff;
  logic acc;
  logic mapped;
  int a;
  // Access phase and address decode
  always_comb begin
    acc = psel && penable;
    a = int'(paddr);
    mapped = (paddr[1:0] == 2'b00) && (a <= 16 || (a >= 64 && a < 64 + 4 * NBUF)
             || (a >= 128 && a < 128 + 4 * NBUF));
  end
  // Shadows of what software wrote
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gmask_ff <= MASK_RST;
      tim_ff <= TIMING_RST;
      en_ff <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == ADDR_GMASK) gmask_ff <= pwdata;
      if (paddr == ADDR_TIMING) tim_ff <= pwdata;
      if (paddr == ADDR_CTRL) en_ff <= pwdata[0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ready_tied: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without pslverr");
  a_mapped_clean: assert property (acc && mapped |-> !pslverr)
    else $error("pslverr on mapped address");
  a_refused_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_gmask_readback: assert property (acc && !pwrite && paddr == ADDR_GMASK
    |-> prdata == gmask_ff)
    else $error("global mask readback wrong");
  a_timing_readback: assert property (acc && !pwrite && paddr == ADDR_TIMING
    |-> prdata == (tim_ff & 32'h0003_7F3F))
    else $error("timing readback wrong");
  a_reset_idle: assert property ($rose(rst_n) |-> bus_transmit_pin && prdata == 32'h0)
    else $error("outputs not idle after reset");
  a_dominant_width: assert property ($fell(bus_transmit_pin) |=> !bus_transmit_pin [*7])
    else $error("dominant bit shorter than 8 clocks");
  a_recessive_width: assert property ($rose(bus_transmit_pin) |=> bus_transmit_pin [*7])
    else $error("recessive bit shorter than 8 clocks");
  a_disabled_quiet: assert property (!en_ff |-> bus_transmit_pin)
    else $error("transmit while disabled");
  c_answer_sent: cover property ($fell(bus_transmit_pin));
  c_refused: cover property (acc && pslverr);
  c_gmask_read: cover property (acc && !pwrite && paddr == ADDR_GMASK);
endmodule
`default_nettype wire

/* can_node_model.sv */
// Purpose: Far CAN node: sends frames and captures frames sent by the block
// Assumes: Simplified link, SOF plus 32 object bits MSB first plus 7 recessive bits
// Notes:   Bit length in clocks comes from the bench
`timescale 1ns/1ps
`default_nettype none
module can_node_model (
  input wire logic sys_clk,
  input wire logic dut_tx,
  input wire logic bus_level,
  input wire logic [7:0] bit_clks,
  output logic node_tx,
  output logic cap_valid,
  output logic [31:0] cap_obj
);
  initial begin
    node_tx = 1'b1;
    cap_valid = 1'b0;
    cap_obj = 32'h0;
  end
  // ----------------------------------------------------------------
  // Frame sender, recessive when idle
  // ----------------------------------------------------------------
  task automatic send(input logic [31:0] obj);
    @(posedge sys_clk);
    node_tx <= 1'b0;
    repeat (bit_clks) @(posedge sys_clk);
    for (int i = 31; i >= 0; i--) begin
      node_tx <= obj[i];
      repeat (bit_clks) @(posedge sys_clk);
    end
    node_tx <= 1'b1; // End of frame
    repeat (7 * bit_clks) @(posedge sys_clk);
  endtask
  // Capture of frames started on the transmit pin, bits sampled mid-bit from the bus
  always begin
    @(negedge dut_tx);
    repeat (bit_clks / 2) @(posedge sys_clk);
    for (int i = 31; i >= 0; i--) begin
      repeat (bit_clks) @(posedge sys_clk);
      cap_obj[i] = bus_level;
    end
    cap_valid <= 1'b1;
    @(posedge sys_clk);
    cap_valid <= 1'b0;
  end
endmodule
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for the CAN remote-frame timing block
// Assumes: Zero-wait APB slave, far node on a wired-AND bus
// Notes:   Two rounds at two bit timings, each after a reset
`timescale 1ns/1ps
`default_nettype none
module tb import can_rf_pkg::*;;
  localparam int NBUF = 15;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic bus_transmit_pin, bus_receive_pin, node_tx, cap_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cap_obj, id, tim, m;
  logic [7:0] bit_clks;
  logic [32:0] exp_obj;
  logic [32:0] rd_q[$];
  logic [31:0] frame_q[$];
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int bit_t, g;
  can_remote_frame_timing #(.NBUF(NBUF)) can_remote_frame_timing_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin));
  can_node_model can_node_model_inst (
    .sys_clk(sys_clk), .dut_tx(bus_transmit_pin), .bus_level(bus_receive_pin),
    .bit_clks(bit_clks), .node_tx(node_tx), .cap_valid(cap_valid), .cap_obj(cap_obj));
  assign bus_receive_pin = bus_transmit_pin & node_tx; // Wired-AND bus
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [32:0] st(input buf_status_type s);
    return {29'h0, s};
  endfunction
  // Output watcher and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      check({pslverr, prdata}, rd_q.pop_front());
    if (cap_valid === 1'b1) begin
      exp_obj = (frame_q.size() > 0) ? {1'b0, frame_q.pop_front()} : 33'h1_0000_0000;
      check({1'b0, cap_obj}, exp_obj);
    end
    if (cycles == 40000) begin
      fail_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h7C187991));
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    bit_clks = 8'h08;
    for (int r = 0; r < 2; r++) begin
      tim = (r == 0) ? TIMING_RST : 32'h0000_1201; // 8 clocks per bit in round 0, 18 in round 1
      bit_t = (int'(tim[5:0]) + 2) * (3 + int'(tim[11:8]) + int'(tim[14:12]));
      bit_clks <= 8'(bit_t);
      rst_n <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(ADDR_CTRL, 33'h0);
      rd(ADDR_TIMING, {1'b0, TIMING_RST});
      rd(ADDR_BMASK, {1'b0, MASK_RST});
      rd(12'h080, st(BUF_OFF));
      rd(12'hFFC, 33'h1_0000_0000);
      rd(12'(64 + 4 * NBUF), 33'h1_0000_0000);
      m = $urandom;
      apb(1'b1, ADDR_GMASK, m);
      apb(1'b1, ADDR_BMASK, ~m);
      rd(ADDR_GMASK, {1'b0, m});
      rd(ADDR_BMASK, {1'b0, ~m});
      apb(1'b1, ADDR_TIMING, tim);
      rd(ADDR_TIMING, {1'b0, tim});
      apb(1'b1, ADDR_GMASK, 32'hFFEF_FFFE); // Remote bits ignored
      apb(1'b1, ADDR_BMASK, 32'hFFEF_FFFE);
      id = $urandom & 32'hFFE0_0000;
      // Buffers 0 and 1 match, buffer 2 differs, buffer 3 receives
      for (int i = 0; i < 4; i++) begin
        apb(1'b1, 12'(64 + 4 * i), (i == 2) ? id ^ 32'h0020_0000 : id);
        apb(1'b1, 12'(128 + 4 * i), (i == 3) ? 32'h1 : {28'h0, TX_REMOTE_WAIT_STATUS});
      end
      rd(12'h044, {1'b0, id});
      apb(1'b1, ADDR_CTRL, 32'h1);
      repeat (12 * bit_t) @(posedge sys_clk);
      frame_q.push_back(id); // Answer has remote bit 0
      frame_q.push_back(id); // Second matching buffer answers as well
      can_node_model_inst.send(id | 32'h0010_0000);
      g = 0;
      while (bus_transmit_pin !== 1'b0 && g < 5000) begin
        @(posedge sys_clk);
        g++;
      end
      check(33'(g >= 2 * bit_t && g <= 5 * bit_t), 33'h1);
      rd(12'h080, st(TX_ONCE_REMOTE_STATUS));
      rd(12'h084, st(TX_ONCE_REMOTE_STATUS));
      rd(12'h088, st(TX_REMOTE_WAIT_STATUS));
      rd(12'h08C, st(RX_FULL));
      repeat (100 * bit_t) @(posedge sys_clk);
    end
    check(33'(frame_q.size()), 33'h0);
    close_out();
  end
endmodule
bind can_remote_frame_timing can_rf_props #(.NBUF(NBUF)) can_rf_props_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin));
`default_nettype wire
